// >>> rtl/asxt_consts.svh
// offsets, field positions, reset values and codes of the datapath block
`ifndef ASXT_CONSTS_SVH
`define ASXT_CONSTS_SVH

`define ASXT_OFF_CMD      8'h00
`define ASXT_OFF_ACC      8'h04
`define ASXT_OFF_STATUS   8'h08
`define ASXT_OFF_DIR      8'h0c
`define ASXT_OFF_FADDR    8'h10
`define ASXT_OFF_FDATA    8'h14

`define ASXT_CMD_OP_MSB   2
`define ASXT_CMD_OP_LSB   0
`define ASXT_CMD_D_BIT    7
`define ASXT_CMD_F_MSB    14
`define ASXT_CMD_F_LSB    8
`define ASXT_CMD_K_MSB    23
`define ASXT_CMD_K_LSB    16

`define ASXT_ST_C         0
`define ASXT_ST_DC        1
`define ASXT_ST_Z         2

`define ASXT_DIR_A_LSB    0
`define ASXT_DIR_B_LSB    8
`define ASXT_DIR_C_LSB    16

`define ASXT_SEL_PORT_A   7'h05
`define ASXT_SEL_PORT_B   7'h06
`define ASXT_SEL_PORT_C   7'h07

`define ASXT_DIR_RESET    8'hff
`define ASXT_ACC_RESET    8'h00
`define ASXT_FILE_RESET   8'h00
`define ASXT_DEST_ACC     1'b0
`define ASXT_DEST_FILE    1'b1
`define ASXT_HSIZE_WORD   3'h2
`define ASXT_ADDR_MSB     7
`define ASXT_FILE_DEPTH   128

`endif

// >>> rtl/asxt_pkg.sv
// types and shared helpers of the datapath block
package asxt_pkg;

  typedef enum logic [2:0] {
    ASXT_OP_NOP  = 3'h0,
    ASXT_OP_SUBB = 3'h1,
    ASXT_OP_SWAP = 3'h2,
    ASXT_OP_DIR  = 3'h3,
    ASXT_OP_XORI = 3'h4,
    ASXT_OP_XORF = 3'h5
  } asxt_op_e;

  typedef logic [7:0] asxt_byte_t;
  typedef logic [6:0] asxt_faddr_t;

  function automatic logic asxt_is_zero(input asxt_byte_t v);
    asxt_is_zero = (v == 8'h00);
  endfunction : asxt_is_zero

endpackage : asxt_pkg

// >>> rtl/asxt_alu.sv
// combinational arithmetic and logic unit of the datapath
`timescale 1ns/100ps
module asxt_alu
  import asxt_pkg::*;
(
  input  wire logic [2:0] op,
  input  wire asxt_byte_t acc,
  input  wire asxt_byte_t fval,
  input  wire asxt_byte_t lit,
  input  wire logic       c_in,
  output asxt_byte_t      result,
  output logic            c_out,
  output logic            dc_out,
  output logic            z_out
);

  logic [8:0] full_sum;
  logic [4:0] nib_sum;

  // f + ~w + c equals f - w - ~c; carry out set means no borrow
  always_comb begin
    full_sum = {1'b0, fval} + {1'b0, ~acc} + {8'h00, c_in};
    nib_sum  = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, c_in};
    c_out    = full_sum[8];
    dc_out   = nib_sum[4];
    case (op)
      ASXT_OP_SUBB: result = full_sum[7:0];
      ASXT_OP_SWAP: result = {fval[3:0], fval[7:4]};
      ASXT_OP_XORI: result = acc ^ lit;
      ASXT_OP_XORF: result = acc ^ fval;
      default:      result = acc;
    endcase
    z_out = asxt_is_zero(result);
  end

endmodule : asxt_alu

// >>> rtl/asxt_top.sv
// datapath block with file registers, flags and ahb-lite register slave
//
// Behaviour
// - subtract with borrow: f minus w minus not-c
// - destination bit 0 to accumulator, 1 to file
// - file operand is seven bits, 0..127
// - nibble exchange swaps halves, flags untouched
// - direction load copies accumulator to port 5/6/7
// - immediate xor into accumulator, only zero flag
// - file xor to destination, only zero flag
`timescale 1ns/100ps
`include "asxt_consts.svh"
module asxt_top
  import asxt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output asxt_byte_t       port_a_direction,
  output asxt_byte_t       port_b_direction,
  output asxt_byte_t       port_c_direction
);

  asxt_byte_t  acc_reg, acc_next;
  asxt_byte_t  file_reg  [`ASXT_FILE_DEPTH];
  asxt_byte_t  file_next [`ASXT_FILE_DEPTH];
  asxt_byte_t  dira_reg, dira_next;
  asxt_byte_t  dirb_reg, dirb_next;
  asxt_byte_t  dirc_reg, dirc_next;
  logic        c_reg, c_next;
  logic        dc_reg, dc_next;
  logic        z_reg, z_next;
  asxt_faddr_t faddr_reg, faddr_next;
  logic        wr_pend_reg, wr_pend_next;
  logic        rd_pend_reg, rd_pend_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic [7:0]  raddr_reg, raddr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic        hready_reg, hready_next;

  logic [2:0]  cmd_op;
  logic        cmd_d;
  asxt_faddr_t cmd_f;
  asxt_byte_t  cmd_k;
  asxt_byte_t  alu_res;
  logic        alu_c;
  logic        alu_dc;
  logic        alu_z;
  logic        accept;

  // command fields ride on the write data of the command register
  assign cmd_op = hwdata[`ASXT_CMD_OP_MSB:`ASXT_CMD_OP_LSB];
  assign cmd_d  = hwdata[`ASXT_CMD_D_BIT];
  assign cmd_f  = hwdata[`ASXT_CMD_F_MSB:`ASXT_CMD_F_LSB];
  assign cmd_k  = hwdata[`ASXT_CMD_K_MSB:`ASXT_CMD_K_LSB];
  assign accept = hsel && htrans[1] && hready;

  asxt_alu u_alu (
    .op     (cmd_op),
    .acc    (acc_reg),
    .fval   (file_reg[cmd_f]),
    .lit    (cmd_k),
    .c_in   (c_reg),
    .result (alu_res),
    .c_out  (alu_c),
    .dc_out (alu_dc),
    .z_out  (alu_z)
  );

  always_comb begin
    acc_next     = acc_reg;
    file_next    = file_reg;
    dira_next    = dira_reg;
    dirb_next    = dirb_reg;
    dirc_next    = dirc_reg;
    c_next       = c_reg;
    dc_next      = dc_reg;
    z_next       = z_reg;
    faddr_next   = faddr_reg;
    wr_pend_next = wr_pend_reg;
    rd_pend_next = rd_pend_reg;
    waddr_next   = waddr_reg;
    raddr_next   = raddr_reg;
    hrdata_next  = hrdata_reg;
    hready_next  = hready_reg;

    // address phase; only the low byte of haddr is decoded
    if (hready) begin
      wr_pend_next = accept && hwrite && (hsize == `ASXT_HSIZE_WORD);
      waddr_next   = haddr[`ASXT_ADDR_MSB:0];
      if (accept && !hwrite) begin
        rd_pend_next = 1'b1;
        raddr_next   = haddr[`ASXT_ADDR_MSB:0];
        hready_next  = 1'b0;
      end
    end

    // one wait state so a read sees a write committed just before it
    if (rd_pend_reg) begin
      rd_pend_next = 1'b0;
      hready_next  = 1'b1;
      case (raddr_reg)
        `ASXT_OFF_ACC:    hrdata_next = {24'h000000, acc_reg};
        `ASXT_OFF_STATUS: hrdata_next = {29'h00000000, z_reg, dc_reg, c_reg};
        `ASXT_OFF_DIR:    hrdata_next = {8'h00, dirc_reg, dirb_reg, dira_reg};
        `ASXT_OFF_FADDR:  hrdata_next = {25'h0000000, faddr_reg};
        `ASXT_OFF_FDATA:  hrdata_next = {24'h000000, file_reg[faddr_reg]};
        default:          hrdata_next = 32'h00000000;
      endcase
    end

    // write data phase, zero wait
    if (wr_pend_reg) begin
      case (waddr_reg)
        `ASXT_OFF_CMD: begin
          case (cmd_op)
            ASXT_OP_SUBB, ASXT_OP_SWAP, ASXT_OP_XORF: begin
              if (cmd_d == `ASXT_DEST_FILE) begin
                file_next[cmd_f] = alu_res;
              end else begin
                acc_next = alu_res;
              end
              if (cmd_op == ASXT_OP_SUBB) begin
                c_next  = alu_c;
                dc_next = alu_dc;
              end
              // nibble exchange leaves every flag alone
              if (cmd_op != ASXT_OP_SWAP) begin
                z_next = alu_z;
              end
            end
            ASXT_OP_XORI: begin
              acc_next = alu_res;
              z_next   = alu_z;
            end
            ASXT_OP_DIR: begin
              // other selector values are ignored, flags untouched
              case (cmd_f)
                `ASXT_SEL_PORT_A: dira_next = acc_reg;
                `ASXT_SEL_PORT_B: dirb_next = acc_reg;
                `ASXT_SEL_PORT_C: dirc_next = acc_reg;
                default: ;
              endcase
            end
            default: ;
          endcase
        end
        `ASXT_OFF_ACC:    acc_next = hwdata[7:0];
        `ASXT_OFF_STATUS: begin
          c_next  = hwdata[`ASXT_ST_C];
          dc_next = hwdata[`ASXT_ST_DC];
          z_next  = hwdata[`ASXT_ST_Z];
        end
        `ASXT_OFF_FADDR:  faddr_next = hwdata[6:0];
        `ASXT_OFF_FDATA:  file_next[faddr_reg] = hwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg     <= `ASXT_ACC_RESET;
      for (int i = 0; i < `ASXT_FILE_DEPTH; i++) begin
        file_reg[i] <= `ASXT_FILE_RESET;
      end
      dira_reg    <= `ASXT_DIR_RESET;
      dirb_reg    <= `ASXT_DIR_RESET;
      dirc_reg    <= `ASXT_DIR_RESET;
      c_reg       <= 1'b0;
      dc_reg      <= 1'b0;
      z_reg       <= 1'b0;
      faddr_reg   <= 7'h00;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      waddr_reg   <= 8'h00;
      raddr_reg   <= 8'h00;
      hrdata_reg  <= 32'h00000000;
      hready_reg  <= 1'b1;
    end else begin
      acc_reg     <= acc_next;
      file_reg    <= file_next;
      dira_reg    <= dira_next;
      dirb_reg    <= dirb_next;
      dirc_reg    <= dirc_next;
      c_reg       <= c_next;
      dc_reg      <= dc_next;
      z_reg       <= z_next;
      faddr_reg   <= faddr_next;
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      waddr_reg   <= waddr_next;
      raddr_reg   <= raddr_next;
      hrdata_reg  <= hrdata_next;
      hready_reg  <= hready_next;
    end
  end

  // response is always okay, so that flop never leaves zero
  logic hresp_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_reg <= 1'b0;
    end else begin
      hresp_reg <= 1'b0;
    end
  end

  assign hrdata           = hrdata_reg;
  assign hreadyout        = hready_reg;
  assign hresp            = hresp_reg;
  assign port_a_direction = dira_reg;
  assign port_b_direction = dirb_reg;
  assign port_c_direction = dirc_reg;

endmodule : asxt_top

// >>> bench/asxt_top_sva.sv
// port assertions of the datapath block
`timescale 1ns/100ps
module asxt_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  port_a_direction,
  input wire logic [7:0]  port_b_direction,
  input wire logic [7:0]  port_c_direction
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic take = hsel && htrans[1] && hready;
  // a command word commits one data phase after its address edge
  wire logic cmd = take && hwrite && haddr[7:0] == 8'h00;
  sequence rd_take; take && !hwrite; endsequence
  sequence one_wait; !hreadyout ##1 hreadyout; endsequence
  chk_read_wait: assert property (rd_take |=> one_wait)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write not zero wait");
  chk_ready_one: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  chk_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  chk_dir_a_load: assert property ($changed(port_a_direction) |->
    $past(cmd, 2) && $past(hwdata[14:8]) == 7'h05 && $past(hwdata[2:0]) == 3'h3)
    else $error("port a direction moved without load");
  chk_dir_b_load: assert property ($changed(port_b_direction) |->
    $past(cmd, 2) && $past(hwdata[14:8]) == 7'h06 && $past(hwdata[2:0]) == 3'h3)
    else $error("port b direction moved without load");
  chk_dir_c_load: assert property ($changed(port_c_direction) |->
    $past(cmd, 2) && $past(hwdata[14:8]) == 7'h07 && $past(hwdata[2:0]) == 3'h3)
    else $error("port c direction moved without load");
endmodule : asxt_chk

bind asxt_top asxt_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
  .port_c_direction(port_c_direction));

// >>> bench/test_asxt_top.sv
// self-checking bench of the datapath block
`timescale 1ns/100ps
module test_asxt_top;
  import asxt_pkg::*;
  logic        hclk = 0, hresetn = 0, hwrite = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic        hreadyout, hresp;
  asxt_byte_t  pa, pb, pc, ac, fv, r;
  asxt_byte_t  dr [3];
  logic        c, n, z;
  logic [8:0]  s9;
  int          fails = 0, checked = 0;
  asxt_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .port_a_direction(pa), .port_b_direction(pb), .port_c_direction(pc));
  always #25 hclk = ~hclk;
  // values are read right after the edge, before the design's updates land
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask : chk
  task step(input logic [2:0] op, input logic [6:0] f, input logic d,
            input asxt_byte_t k, a, v, input logic [2:0] st);
    xfer(1, 8'h04, a);
    xfer(1, 8'h08, st);
    xfer(1, 8'h10, f);
    xfer(1, 8'h14, v);
    xfer(1, 8'h00, {8'h0, k, 1'b0, f, d, 4'h0, op});
    {z, n, c} = st;
    ac = a;
    fv = v;
    r = 8'h00;
    case (op)
      3'h1: begin
        s9 = {1'b0, v} + {1'b0, ~a} + c;
        r = s9[7:0];
        // nibble borrow must use the incoming carry, so update c afterwards
        n = ({1'b0, v[3:0]} + {1'b0, ~a[3:0]} + c) >> 4;
        c = s9[8];
      end
      3'h2: r = {v[3:0], v[7:4]};
      3'h3: if (f inside {7'h05, 7'h06, 7'h07}) dr[f - 5] = a;
      3'h4: ac = a ^ k;
      3'h5: r = a ^ v;
      default: ;
    endcase
    if (op inside {3'h1, 3'h4, 3'h5}) z = (op == 3'h4 ? ac : r) == 8'h00;
    if (op inside {3'h1, 3'h2, 3'h5}) begin
      if (d) fv = r;
      else ac = r;
    end
    xfer(0, 8'h04, 0);
    chk("acc", {24'h0, ac}, q);
    xfer(0, 8'h08, 0);
    chk("status", {29'h0, z, n, c}, q);
    xfer(0, 8'h14, 0);
    chk("file", {24'h0, fv}, q);
    chk("dirs", {dr[0], dr[1], dr[2]}, {pa, pb, pc});
  endtask : step
  task tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #2000000;
    fails++;
    tally_and_finish;
  end
  initial begin
    dr = '{8'hff, 8'hff, 8'hff};
    void'($urandom(32'hf8d8));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, 8'h08, 0);
    chk("status reset", 0, q);
    xfer(1, 8'h18, 32'hffffffff);
    xfer(0, 8'h18, 0);
    chk("unmapped", 0, q);
    // corner cases: every direction select, a stray one, top file address
    for (int i = 4; i < 8; i++) step(3'h3, 7'(i), 0, 0, 8'($urandom), 0, 0);
    step(3'h4, 7'h7f, 0, 8'h5a, 8'h5a, 0, 3'h3);
    step(3'h5, 7'h7f, 1, 0, 8'hc3, 8'hc3, 0);
    step(3'h1, 7'h00, 0, 0, 8'h00, 8'h00, 3'h0);
    step(3'h1, 7'h7f, 1, 0, 8'h01, 8'h01, 3'h1);
    repeat (300) step(3'($urandom), 7'($urandom), 1'($urandom), 8'($urandom),
                      8'($urandom), 8'($urandom), 3'($urandom));
    tally_and_finish;
  end
endmodule : test_asxt_top
